//--- core/ida_core.sv
/*
 * indirect data addressing unit: three 12-bit pointers, five virtual
 * operands per pointer, bank selector and working register copy.
 * assumes a plain register port from the instruction core and a data
 * memory with combinational read data, written on the same edge.
 */
// Design decisions made here: the address-and-strobe port and the register offsets.
// What this block does
// - the plain operand accesses memory at the pointer and leaves it unchanged.
// - the post-increment operand uses the pointer then adds one to it.
// - the post-decrement operand uses the pointer then subtracts one from it.
// - the pre-increment operand adds one first and uses the new pointer.
// - the indexed operand addresses memory at pointer plus sign-extended working register.
// - virtual operands hold no storage and go straight to data memory.
// - the pointer high byte keeps four bits, cleared at reset.
// - the pointer low byte gives the eight low bits and is loaded with zero at reset.
// - the bank selector keeps four bits, cleared at reset.
`timescale 1ns/10ps
`include "ida_regs.svh"

module ida_core
    import ida_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    // register port
    input  wire logic [5:0]  I_ADDR,
    input  wire logic [7:0]  I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [7:0]  O_RDATA,
    // data memory
    output logic      [11:0] O_MEM_ADDR,
    output logic      [7:0]  O_MEM_WDATA,
    output logic             O_MEM_WR,
    output logic             O_MEM_RD,
    input  wire logic [7:0]  I_MEM_RDATA,
    // state seen by the core
    output logic      [3:0]  O_BANK,
    output logic      [7:0]  O_WORK
);

    // ======================================================================
    // elaboration check; the 4 + 8 split of a pointer is fixed in the logic
    if (ADDR_W != 12) begin : g_bad_width
        $error("ida_core serves only a 12-bit address");
    end

    ida_state_s st;
    ida_state_s next_st;
    logic       acc;
    logic [1:0] sel;
    logic [3:0] idx;
    ida_mode_e  mode;
    ida_addr_t  cur;
    ida_addr_t  inc;
    ida_addr_t  dec;
    ida_addr_t  eff;
    ida_addr_t  upd;

    assign acc = I_WR | I_RD;
    assign sel = I_ADDR[`IDA_PTR_SEL_HI:`IDA_PTR_SEL_LO];
    assign idx = I_ADDR[3:0];

    // ======================================================================
    // operand decode; select 3 holds no pointer
    always_comb begin
        mode = IDA_MODE_NONE;
        if (sel != 2'b11) begin
            unique case (idx)
                `IDA_OFF_PLAIN:    mode = IDA_MODE_PLAIN;
                `IDA_OFF_POST_INC: mode = IDA_MODE_POST_INC;
                `IDA_OFF_POST_DEC: mode = IDA_MODE_POST_DEC;
                `IDA_OFF_PRE_INC:  mode = IDA_MODE_PRE_INC;
                `IDA_OFF_INDEXED:  mode = IDA_MODE_INDEXED;
                default:           mode = IDA_MODE_NONE;
            endcase
        end
    end

    // ======================================================================
    // address arithmetic, all modulo 4096
    assign cur = (sel != 2'b11) ? st.ptr[sel] : 12'h000;
    assign inc = cur + 12'h001;
    assign dec = cur - 12'h001;

    always_comb begin
        eff = cur;
        upd = cur;
        unique case (mode)
            IDA_MODE_POST_INC: upd = inc;
            IDA_MODE_POST_DEC: upd = dec;
            IDA_MODE_PRE_INC: begin
                eff = inc;
                upd = inc;
            end
            // sign-extended offset, pointer untouched
            IDA_MODE_INDEXED:  eff = cur + {{4{st.work[7]}}, st.work};
            default:           eff = cur;
        endcase
    end

    // ======================================================================
    // memory side: virtual operands pass straight through, no storage
    assign O_MEM_ADDR  = eff;
    assign O_MEM_WDATA = I_WDATA;
    assign O_MEM_WR    = I_WR & (mode != IDA_MODE_NONE);
    assign O_MEM_RD    = I_RD & (mode != IDA_MODE_NONE);
    assign O_RDATA     = st.rdata;
    assign O_BANK      = st.bank;
    assign O_WORK      = st.work;

    // ======================================================================
    // next state
    always_comb begin
        next_st       = st;
        next_st.rdata = 8'h00;
        if (acc && mode != IDA_MODE_NONE) begin
            next_st.ptr[sel] = upd;
        end
        if (I_RD) begin
            if (mode != IDA_MODE_NONE) begin
                next_st.rdata = I_MEM_RDATA;
            end else if (idx == `IDA_OFF_BANK) begin
                next_st.rdata = {4'h0, st.bank};
            end else if (idx == `IDA_OFF_WORK) begin
                next_st.rdata = st.work;
            end else if (sel != 2'b11 && idx == `IDA_OFF_PTR_HIGH) begin
                next_st.rdata = {4'h0, cur[11:8]};
            end else if (sel != 2'b11 && idx == `IDA_OFF_PTR_LOW) begin
                next_st.rdata = cur[7:0];
            end
        end
        if (I_WR) begin
            if (idx == `IDA_OFF_BANK) begin
                next_st.bank = I_WDATA[3:0];
            end else if (idx == `IDA_OFF_WORK) begin
                next_st.work = I_WDATA;
            end else if (sel != 2'b11 && idx == `IDA_OFF_PTR_HIGH) begin
                next_st.ptr[sel][11:8] = I_WDATA[3:0];
            end else if (sel != 2'b11 && idx == `IDA_OFF_PTR_LOW) begin
                next_st.ptr[sel][7:0] = I_WDATA;
            end
        end
    end

    // ======================================================================
    // state register; low bytes get a constant only because the flop
    // needs one, software must not rely on it
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            for (int i = 0; i < 3; i++) begin
                st.ptr[i] <= {`IDA_RST_HIGH, `IDA_RST_LOW};
            end
            st.bank  <= `IDA_RST_BANK;
            st.work  <= 8'h00;
            st.rdata <= 8'h00;
        end else begin
            st <= next_st;
        end
    end

    // ======================================================================
    // notes for whoever wires this block in
    // - the memory must answer a read in the strobe cycle; the read data is
    //   registered here, so the core sees it one cycle after its strobe
    // - a pointer step and the memory access share one edge, so a read and
    //   the pointer update never split across two instruction cycles
    // - a write to a virtual operand also steps the pointer; there is no
    //   way to write memory through post-increment without the step
    // - the indexed offset is signed, so a working value of 80..FF reaches
    //   backwards; software that wants an unsigned reach must split it
    // - low bytes come out of reset at zero only because the flops need a
    //   value; software must write them before first use
    // - select 3 has no pointer; its operand slots read zero and ignore
    //   writes, while bank and working register answer on any select
    // - both strobes at once is not a legal request; the write then wins
    //   for the local registers and the memory sees both strobes
    // - high nibble bits of a pointer high byte are dropped on write and
    //   read back as zero, so junk there cannot reach the address
    // - wrap-around is silent: no flag marks a step across 000 or FFF
    // - the read path holds no buffer; a read of an operand that nobody
    //   wrote returns whatever the memory holds at that address
    // - checks below are simulation only and add no logic

    // ======================================================================
    // checks
    // the newer checks lean on these defaults; the older ones carry their own
    default clocking cb_chk @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);

    logic [11:0] p0_past;
    assign p0_past = st.ptr[0];

    sequence s_touch(logic [3:0] k);
        acc && sel == 2'b00 && idx == k;
    endsequence

    a_plain_hold: assert property (@(posedge I_CLK) disable iff (I_RST)
        s_touch(`IDA_OFF_PLAIN) |=> st.ptr[0] == $past(p0_past))
        else $error("plain operand moved the pointer");
    a_post_inc_step: assert property (@(posedge I_CLK) disable iff (I_RST)
        s_touch(`IDA_OFF_POST_INC) |-> O_MEM_ADDR == st.ptr[0]
        ##1 st.ptr[0] == $past(p0_past) + 12'h001)
        else $error("post-increment wrong");
    a_post_dec_step: assert property (@(posedge I_CLK) disable iff (I_RST)
        s_touch(`IDA_OFF_POST_DEC) |-> O_MEM_ADDR == st.ptr[0]
        ##1 st.ptr[0] == $past(p0_past) - 12'h001)
        else $error("post-decrement wrong");
    a_pre_inc_step: assert property (@(posedge I_CLK) disable iff (I_RST)
        s_touch(`IDA_OFF_PRE_INC) |-> O_MEM_ADDR == st.ptr[0] + 12'h001
        ##1 st.ptr[0] == $past(O_MEM_ADDR))
        else $error("pre-increment wrong");
    a_indexed_addr: assert property (@(posedge I_CLK) disable iff (I_RST)
        s_touch(`IDA_OFF_INDEXED) |-> O_MEM_ADDR ==
        st.ptr[0] + {{4{st.work[7]}}, st.work})
        else $error("indexed address wrong");
    a_indexed_keep: assert property (@(posedge I_CLK) disable iff (I_RST)
        s_touch(`IDA_OFF_INDEXED) |=> $stable(st.ptr[0]))
        else $error("indexed operand moved the pointer");
    a_read_pass: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_RD && mode != IDA_MODE_NONE |-> O_MEM_RD
        ##1 O_RDATA == $past(I_MEM_RDATA))
        else $error("virtual read not passed through");
    a_wrap_top: assert property (@(posedge I_CLK) disable iff (I_RST)
        acc && sel == 2'b00 && idx == `IDA_OFF_POST_INC && st.ptr[0] == 12'hFFF
        |=> st.ptr[0] == 12'h000)
        else $error("pointer did not wrap");
    a_bank_write: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_WR && idx == `IDA_OFF_BANK && mode == IDA_MODE_NONE
        |=> O_BANK == $past(I_WDATA[3:0]))
        else $error("bank write lost");
    a_high_read: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_RD && sel == 2'b01 && idx == `IDA_OFF_PTR_HIGH
        |=> O_RDATA[7:4] == 4'h0)
        else $error("high byte upper nibble not zero");

    // ======================================================================
    // per-pointer checks, one copy for each of the three pointers
    for (genvar p = 0; p < 3; p++) begin : g_ptr_chk
        // an access aimed at this pointer through register index k
        sequence s_hit(logic [3:0] k);
            acc && sel == 2'(p) && idx == k;
        endsequence

        // plain operand leaves the pointer where it was
        a_plain_keep: assert property (
            s_hit(`IDA_OFF_PLAIN) |=> $stable(st.ptr[p]))
            else $error("plain operand moved a pointer");

        // post-increment addresses with the old value
        a_post_inc_addr: assert property (
            s_hit(`IDA_OFF_POST_INC) |-> O_MEM_ADDR == st.ptr[p])
            else $error("post-increment address wrong");

        // post-increment then steps up by one
        a_post_inc_move: assert property (
            s_hit(`IDA_OFF_POST_INC) |=> st.ptr[p] == $past(st.ptr[p]) + 12'h001)
            else $error("post-increment step wrong");

        // post-decrement addresses with the old value
        a_post_dec_addr: assert property (
            s_hit(`IDA_OFF_POST_DEC) |-> O_MEM_ADDR == st.ptr[p])
            else $error("post-decrement address wrong");

        // post-decrement then steps down by one
        a_post_dec_move: assert property (
            s_hit(`IDA_OFF_POST_DEC) |=> st.ptr[p] == $past(st.ptr[p]) - 12'h001)
            else $error("post-decrement step wrong");

        // pre-increment addresses with the stepped value
        a_pre_inc_addr: assert property (
            s_hit(`IDA_OFF_PRE_INC) |-> O_MEM_ADDR == st.ptr[p] + 12'h001)
            else $error("pre-increment address wrong");

        // pre-increment keeps the value it addressed with
        a_pre_inc_move: assert property (
            s_hit(`IDA_OFF_PRE_INC) |=> st.ptr[p] == $past(O_MEM_ADDR))
            else $error("pre-increment step wrong");

        // indexed address is pointer plus signed working value
        a_indexed_sum: assert property (
            s_hit(`IDA_OFF_INDEXED) |-> O_MEM_ADDR == st.ptr[p] + {{4{st.work[7]}}, st.work})
            else $error("indexed address wrong");

        // indexed access leaves the pointer alone
        a_indexed_still: assert property (
            s_hit(`IDA_OFF_INDEXED) |=> $stable(st.ptr[p]))
            else $error("indexed operand moved a pointer");

        // high byte write keeps only the low nibble
        a_high_write: assert property (
            I_WR && sel == 2'(p) && idx == `IDA_OFF_PTR_HIGH
            |=> st.ptr[p][11:8] == $past(I_WDATA[3:0]))
            else $error("high byte write lost");

        // high byte reads back with a zero upper nibble
        a_high_back: assert property (
            I_RD && sel == 2'(p) && idx == `IDA_OFF_PTR_HIGH
            |=> O_RDATA == {4'h0, $past(st.ptr[p][11:8])})
            else $error("high byte read wrong");

        // low byte write lands whole
        a_low_write: assert property (
            I_WR && sel == 2'(p) && idx == `IDA_OFF_PTR_LOW
            |=> st.ptr[p][7:0] == $past(I_WDATA))
            else $error("low byte write lost");

        // low byte reads back whole
        a_low_back: assert property (
            I_RD && sel == 2'(p) && idx == `IDA_OFF_PTR_LOW
            |=> O_RDATA == $past(st.ptr[p][7:0]))
            else $error("low byte read wrong");

        // high nibble is clear once reset has been seen on an edge
        a_reset_high: assert property (@(posedge I_CLK) disable iff (1'b0)
            I_RST ##1 I_RST |-> st.ptr[p][11:8] == `IDA_RST_HIGH)
            else $error("high byte not cleared by reset");

        // traffic for another select never moves this pointer
        a_other_still: assert property (
            acc && sel != 2'(p) |=> $stable(st.ptr[p]))
            else $error("foreign access moved a pointer");

        // a step down from zero wraps to the top
        a_wrap_down: assert property (
            s_hit(`IDA_OFF_POST_DEC) && st.ptr[p] == 12'h000 |=> st.ptr[p] == 12'hFFF)
            else $error("pointer did not wrap down");

        // operand read hands the memory byte through
        a_read_mem: assert property (
            I_RD && sel == 2'(p) && mode != IDA_MODE_NONE
            |-> O_MEM_RD ##1 O_RDATA == $past(I_MEM_RDATA))
            else $error("operand read not passed");

        // operand write reaches memory in the strobe cycle
        a_write_mem: assert property (
            I_WR && sel == 2'(p) && mode != IDA_MODE_NONE
            |-> O_MEM_WR && O_MEM_WDATA == I_WDATA)
            else $error("operand write not passed");
    end

    // ======================================================================
    // checks of the local registers and of refusals
    // read data stands one cycle only, zero otherwise
    a_rdata_idle: assert property (
        !I_RD |=> O_RDATA == 8'h00)
        else $error("read data outside a read");

    // unmapped indices read zero
    a_unmapped_zero: assert property (
        I_RD && idx > `IDA_OFF_WORK |=> O_RDATA == 8'h00)
        else $error("unmapped index read not zero");

    // select 3 never touches memory
    a_sel3_inert: assert property (
        acc && sel == 2'b11 |-> !O_MEM_WR && !O_MEM_RD)
        else $error("select 3 reached memory");

    // bank selector reads back with a zero upper nibble
    a_bank_read: assert property (
        I_RD && mode == IDA_MODE_NONE && idx == `IDA_OFF_BANK
        |=> O_RDATA == {4'h0, $past(O_BANK)})
        else $error("bank read wrong");

    // working register takes the written byte
    a_work_write: assert property (
        I_WR && mode == IDA_MODE_NONE && idx == `IDA_OFF_WORK
        |=> O_WORK == $past(I_WDATA))
        else $error("working register write lost");

    // bank is clear once reset has been seen on an edge
    a_reset_bank: assert property (@(posedge I_CLK) disable iff (1'b0)
        I_RST ##1 I_RST |-> O_BANK == `IDA_RST_BANK)
        else $error("bank not cleared by reset");

endmodule

//--- include/ida_pkg.sv
/*
 * types of the indirect addressing unit.
 * assumes nothing beyond the constants header.
 */
package ida_pkg;
    // ======================================================================
    // access kinds of a virtual operand
    typedef enum logic [2:0] {
        IDA_MODE_NONE     = 3'b000,
        IDA_MODE_PLAIN    = 3'b001,
        IDA_MODE_POST_INC = 3'b010,
        IDA_MODE_POST_DEC = 3'b011,
        IDA_MODE_PRE_INC  = 3'b100,
        IDA_MODE_INDEXED  = 3'b101
    } ida_mode_e;

    typedef logic [11:0] ida_addr_t;

    // whole state of the block
    typedef struct packed {
        logic [2:0][11:0] ptr;
        logic [3:0]       bank;
        logic [7:0]       work;
        logic [7:0]       rdata;
    } ida_state_s;
endpackage

//--- include/ida_regs.svh
/*
 * register indices and field layouts of the indirect addressing unit.
 * assumes the plain register port with 4-bit indices below.
 */
`ifndef IDA_REGS_SVH
`define IDA_REGS_SVH

// ==========================================================================
// register indices (4 bits, chosen locally)
`define IDA_OFF_PLAIN      4'h0
`define IDA_OFF_POST_INC   4'h1
`define IDA_OFF_POST_DEC   4'h2
`define IDA_OFF_PRE_INC    4'h3
`define IDA_OFF_INDEXED    4'h4
`define IDA_OFF_PTR_HIGH   4'h5
`define IDA_OFF_PTR_LOW    4'h6
`define IDA_OFF_BANK       4'h7
`define IDA_OFF_WORK       4'h8
// pointer select sits in address bits 5:4
`define IDA_PTR_SEL_HI     5
`define IDA_PTR_SEL_LO     4
// ==========================================================================
// reset values
`define IDA_RST_HIGH       4'h0
`define IDA_RST_BANK       4'h0
`define IDA_RST_LOW        8'h00

`endif

//--- test/ida_mem_model.sv
/*
 * data memory model on the far side of the addressing unit.
 * assumes one clock, combinational read in the strobe cycle, write on the edge.
 */
`timescale 1ns/10ps
module ida_mem_model (
    // clock
    input  wire logic        i_clk,
    // memory side of the unit
    input  wire logic [11:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata
);
    logic [7:0] mem [4096];
    logic [7:0] junk = 8'h5A;
    // ======================================================================
    // storage; junk moves every cycle so a read outside a strobe shows
    always @(posedge i_clk) begin
        junk <= junk + 8'h3B;
        if (i_wr) mem[i_addr] <= i_wdata;
    end
    // read data only while strobed, never a held value
    assign o_rdata = i_rd ? mem[i_addr] : junk;
endmodule

//--- test/indirect_data_addressing_test.sv
/*
 * self-checking bench of the indirect addressing unit.
 * assumes ida_core beside the memory model, one 20 MHz clock.
 */
`timescale 1ns/10ps
`include "ida_regs.svh"
module indirect_data_addressing_test;
    logic        I_CLK   = 1'b0;
    logic        I_RST   = 1'b1;
    logic        I_WR    = 1'b0;
    logic        I_RD    = 1'b0;
    logic [5:0]  I_ADDR  = 6'h00;
    logic [7:0]  I_WDATA = 8'h00;
    logic [7:0]  O_RDATA, I_MEM_RDATA, O_MEM_WDATA, O_WORK, work;
    logic [11:0] O_MEM_ADDR;
    logic        O_MEM_WR, O_MEM_RD;
    logic [3:0]  O_BANK;
    logic [11:0] ptr [3];
    logic [7:0]  mirror [4096];
    int          n_fail = 0, n_checks = 0, cyc = 0;
    // ======================================================================
    // clock, hang guard, design and memory
    always #25 I_CLK = ~I_CLK;
    always @(posedge I_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end
    ida_core i_ida_core (.I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR),
        .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
        .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_WDATA(O_MEM_WDATA), .O_MEM_WR(O_MEM_WR),
        .O_MEM_RD(O_MEM_RD), .I_MEM_RDATA(I_MEM_RDATA), .O_BANK(O_BANK),
        .O_WORK(O_WORK));
    ida_mem_model i_ida_mem_model (.i_clk(I_CLK), .i_addr(O_MEM_ADDR),
        .i_wdata(O_MEM_WDATA), .i_wr(O_MEM_WR), .i_rd(O_MEM_RD),
        .o_rdata(I_MEM_RDATA));
    // ======================================================================
    // expectations
    function automatic logic [5:0] ix(int p, logic [3:0] r);
        return {p[1:0], r};
    endfunction
    function automatic logic [11:0] exp_addr(logic [11:0] p, logic [3:0] k);
        case (k)
            `IDA_OFF_PRE_INC: return p + 12'h001;
            `IDA_OFF_INDEXED: return p + {{4{work[7]}}, work};
            default: return p;
        endcase
    endfunction
    function automatic logic [11:0] next_ptr(logic [11:0] p, logic [3:0] k);
        case (k)
            `IDA_OFF_POST_INC, `IDA_OFF_PRE_INC: return p + 12'h001;
            `IDA_OFF_POST_DEC: return p - 12'h001;
            default: return p;
        endcase
    endfunction
    // ======================================================================
    // bus cycles and compare
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // memory side sampled mid-cycle, read data in the cycle after only
    task automatic acc(input logic [5:0] a, input logic [7:0] d, input logic wr,
                       output logic [7:0] rd, output logic [11:0] ma,
                       output logic [1:0] st);
        @(posedge I_CLK);
        I_ADDR <= a;
        I_WDATA <= d;
        I_WR <= wr;
        I_RD <= !wr;
        @(negedge I_CLK);
        ma = O_MEM_ADDR;
        st = {O_MEM_WR, O_MEM_RD};
        if (wr && st[1]) chk(O_MEM_WDATA, d);
        @(posedge I_CLK);
        I_WR <= 1'b0;
        I_RD <= 1'b0;
        @(negedge I_CLK);
        rd = O_RDATA;
    endtask
    // junk in the high nibble must not reach the pointer
    task automatic setp(input int p, input logic [11:0] v);
        logic [7:0]  rd;
        logic [11:0] ma;
        logic [1:0]  st;
        acc(ix(p, `IDA_OFF_PTR_HIGH), {4'($urandom), v[11:8]}, 1'b1, rd, ma, st);
        acc(ix(p, `IDA_OFF_PTR_LOW), v[7:0], 1'b1, rd, ma, st);
        ptr[p] = v;
    endtask
    task automatic setw(input logic [7:0] w);
        logic [7:0]  rd;
        logic [11:0] ma;
        logic [1:0]  st;
        acc(ix(0, `IDA_OFF_WORK), w, 1'b1, rd, ma, st);
        work = w;
        chk(O_WORK, w);
        acc(ix(0, `IDA_OFF_WORK), 8'h00, 1'b0, rd, ma, st);
        chk(rd, w);
    endtask
    // operand access, then read the pointer back
    task automatic op(input int p, input logic [3:0] k, input logic wr);
        logic [7:0]  d, rd;
        logic [11:0] ma, ea;
        logic [1:0]  st;
        d = 8'($urandom);
        ea = exp_addr(ptr[p], k);
        acc(ix(p, k), d, wr, rd, ma, st);
        chk(ma, ea);
        chk(st, {wr, !wr});
        if (wr) mirror[ea] = d;
        else if (!$isunknown(mirror[ea])) chk(rd, mirror[ea]);
        ptr[p] = next_ptr(ptr[p], k);
        acc(ix(p, `IDA_OFF_PTR_LOW), 8'h00, 1'b0, rd, ma, st);
        chk(rd, ptr[p][7:0]);
        acc(ix(p, `IDA_OFF_PTR_HIGH), 8'h00, 1'b0, rd, ma, st);
        chk(rd, {4'h0, ptr[p][11:8]});
    endtask
    task automatic final_report;
        if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ======================================================================
    // reset, refusals, wrap corners, then random traffic
    initial begin
        logic [7:0]  rd;
        logic [11:0] ma;
        logic [1:0]  st;
        logic [11:0] cv [5] = '{12'hFFF, 12'h000, 12'h0FF, 12'h100, 12'h010};
        logic [3:0]  ck [5] = '{4'h1, 4'h2, 4'h3, 4'h2, 4'h4};
        void'($urandom(32'hF0A6));
        repeat (20) @(posedge I_CLK);
        I_RST <= 1'b0;
        @(negedge I_CLK);
        chk(O_BANK, 12'h000);
        for (int p = 0; p < 3; p++) begin
            acc(ix(p, `IDA_OFF_PTR_HIGH), 8'h00, 1'b0, rd, ma, st);
            chk(rd, 12'h000);
        end
        acc(ix(0, 4'hF), 8'hFF, 1'b1, rd, ma, st);
        chk(st, 12'h000);
        acc(ix(0, 4'hF), 8'h00, 1'b0, rd, ma, st);
        chk(rd, 12'h000);
        acc(ix(3, `IDA_OFF_PLAIN), 8'h11, 1'b1, rd, ma, st);
        chk(st, 12'h000);
        acc(ix(3, `IDA_OFF_BANK), 8'hA5, 1'b1, rd, ma, st);
        chk(O_BANK, 12'h005);
        acc(ix(3, `IDA_OFF_BANK), 8'h00, 1'b0, rd, ma, st);
        chk(rd, 12'h005);
        setw(8'h80);
        for (int i = 0; i < 5; i++) begin
            setp(i % 3, cv[i]);
            op(i % 3, ck[i], i[0]);
        end
        for (int p = 0; p < 3; p++) setp(p, 12'($urandom));
        repeat (200) begin
            automatic int p = $urandom_range(2);
            if ($urandom_range(9) == 0) setw(8'($urandom));
            if ($urandom_range(9) == 1) setp(p, 12'($urandom));
            op(p, 4'($urandom_range(4)), 1'($urandom_range(1)));
        end
        final_report();
    end
endmodule
